// [common/rtctk_consts.vh]
// Constants of the real-time clock timekeeper and its slow-clock source selection
`ifndef RTCTK_CONSTS_VH
`define RTCTK_CONSTS_VH

// Register offsets of the time, calendar and alarm bytes
`define RTCTK_ADDR_TIME_SECONDS 8'h10
`define RTCTK_ADDR_ALARM_SECONDS 8'h11
`define RTCTK_ADDR_TIME_MINUTES 8'h12
`define RTCTK_ADDR_ALARM_MINUTES 8'h13
`define RTCTK_ADDR_TIME_HOURS 8'h14
`define RTCTK_ADDR_ALARM_HOURS 8'h15
`define RTCTK_ADDR_WEEKDAY 8'h16
`define RTCTK_ADDR_MONTH_DAY 8'h17
`define RTCTK_ADDR_CALENDAR_MONTH 8'h18
`define RTCTK_ADDR_CALENDAR_YEAR 8'h19
// Control, status, flag and charger registers
`define RTCTK_ADDR_CONTROL 8'h1a
`define RTCTK_ADDR_STATUS 8'h1b
`define RTCTK_ADDR_FLAGS 8'h1c
`define RTCTK_ADDR_CHARGER 8'h1d

// Byte array indices of the ten data bytes
`define RTCTK_IDX_SEC 4'h0
`define RTCTK_IDX_ASEC 4'h1
`define RTCTK_IDX_MIN 4'h2
`define RTCTK_IDX_AMIN 4'h3
`define RTCTK_IDX_HOUR 4'h4
`define RTCTK_IDX_AHOUR 4'h5
`define RTCTK_IDX_WDAY 4'h6
`define RTCTK_IDX_MDAY 4'h7
`define RTCTK_IDX_MONTH 4'h8
`define RTCTK_IDX_YEAR 4'h9
`define RTCTK_DATA_BYTES 10

// Control register fields
`define RTCTK_CTL_SET_MODE 7
`define RTCTK_CTL_ALARM_IE 6
`define RTCTK_CTL_UPDATE_IE 4
`define RTCTK_CTL_DATA_MODE 2
`define RTCTK_CTL_HOUR_24 1
`define RTCTK_CTL_CLKOUT_DIS 0
`define RTCTK_CTL_RESET 8'h02
`define RTCTK_CTL_MASK 8'hd7
// Status register fields
`define RTCTK_STS_UPDATE_PENDING 7
`define RTCTK_STS_CLOCK_SOURCE 0
// Flag register fields
`define RTCTK_FLG_REQUEST 7
`define RTCTK_FLG_ALARM 5
`define RTCTK_FLG_UPDATE 4
`define RTCTK_CHARGER_RESET 8'h00

// Calendar reset values: 00:00:00, Sunday, January 1, 2000
`define RTCTK_RESET_WEEKDAY 8'h01
`define RTCTK_RESET_MONTH_DAY 8'h01
`define RTCTK_RESET_MONTH 8'h01
`define RTCTK_RESET_YEAR 8'h00
`define RTCTK_PM_BIT 7

// Prescaler and update timing
`define RTCTK_PRESCALE_BITS 15
`define RTCTK_PRESCALE_MAX 15'h7fff
`define RTCTK_SLOW_PERIOD_NS 30518
`define RTCTK_UIP_LEAD_NS 244100
`define RTCTK_ALARM_DELAY_NS 30500
`define RTCTK_UIP_LEAD_TICKS (`RTCTK_UIP_LEAD_NS / `RTCTK_SLOW_PERIOD_NS)
`define RTCTK_ALARM_TICKS_RAW (`RTCTK_ALARM_DELAY_NS / `RTCTK_SLOW_PERIOD_NS)
`define RTCTK_ALARM_TICKS ((`RTCTK_ALARM_TICKS_RAW < 1) ? 1 : `RTCTK_ALARM_TICKS_RAW)

// Backup-clock edges without a crystal edge before the crystal counts as stopped
`define RTCTK_XTAL_MISS_LIMIT 3'h4

`endif

// [logic/rtctk_clock_select.v]
// Glitch-free selection between crystal and backup slow clocks
`default_nettype none

`include "rtctk_consts.vh"

module rtctk_clock_select (
    input wire clock_in,
    input wire sys_rst_in,
    input wire xtal_clock_in,
    input wire backup_clock_in,
    output reg slow_clock,
    output reg slow_tick,
    output reg rc_selected
);

    reg xtal_meta;
    reg xtal_sync;
    reg xtal_prev;
    reg rc_meta;
    reg rc_sync;
    reg rc_prev;
    reg [2:0] miss_count;
    wire xtal_rise;
    wire rc_rise;
    wire xtal_alive;
    wire mux_now;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge history
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            xtal_meta <= xtal_clock_in;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
            rc_meta <= backup_clock_in;
            rc_sync <= rc_meta;
            rc_prev <= rc_sync;
        end
    end

    assign xtal_rise = xtal_sync & ~xtal_prev;
    assign rc_rise = rc_sync & ~rc_prev;
    assign xtal_alive = (miss_count < `RTCTK_XTAL_MISS_LIMIT);

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            miss_count <= `RTCTK_XTAL_MISS_LIMIT;
        end else if (xtal_rise) begin
            miss_count <= 3'h0;
        end else if (rc_rise && xtal_alive) begin
            miss_count <= miss_count + 3'h1;
        end
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rc_selected <= 1'b1;
        end else if (!xtal_sync && !rc_sync) begin
            rc_selected <= ~xtal_alive;
        end
    end

    assign mux_now = rc_selected ? rc_sync : xtal_sync;

    // Selected clock and its rising-edge enable
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slow_clock <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            slow_clock <= mux_now;
            slow_tick <= mux_now & ~slow_clock;
        end
    end

endmodule // rtctk_clock_select

`default_nettype wire

// [logic/rtctk_timekeeper.v]
// Real-time clock timekeeper: calendar, alarm, status and clock outputs
`default_nettype none

`include "rtctk_consts.vh"

module rtctk_timekeeper (
    input wire clock_in,
    input wire sys_rst_in,
    input wire xtal_clock_in,
    input wire backup_clock_in,
    input wire audio_clock_in,
    input wire companion_rail_in,
    input wire startup_done_in,
    input wire spi_powered_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    output reg slow_clock_out,
    output reg audio_clock_out,
    output reg rtc_irq_out
);

    reg [7:0] data_byte [0:`RTCTK_DATA_BYTES-1];
    reg [7:0] control;
    reg [7:0] charger;
    reg update_pending_flag;
    reg alarm_match_flag;
    reg update_end_flag;
    reg [`RTCTK_PRESCALE_BITS-1:0] prescale;
    reg compare_pending;
    reg [3:0] compare_count;
    reg audio_meta;
    reg audio_sync;
    reg driver_enable;
    reg [7:0] next_byte [0:`RTCTK_DATA_BYTES-1];
    reg next_alarm_flag;
    reg next_update_flag;
    reg [7:0] sec_b;
    reg [7:0] min_b;
    reg [7:0] hr24_b;
    reg [7:0] wday_b;
    reg [7:0] mday_b;
    reg [7:0] mon_b;
    reg [7:0] year_b;
    reg [7:0] hr12_b;
    reg carry_min;
    reg carry_hr;
    reg carry_day;
    reg carry_mon;
    reg carry_year;
    wire slow_clock;
    wire slow_tick;
    wire rc_selected;
    wire set_mode;
    wire binary_mode;
    wire hour_24;
    wire access_ok;
    wire wr_hit;
    wire rd_flags;
    wire second_tick;
    wire uip_start;
    wire do_update;
    wire do_compare;
    wire alarm_match;
    wire request_flag;
    wire [3:0] wr_index;
    genvar gi;
    integer k;
    localparam integer uip_lead = `RTCTK_UIP_LEAD_TICKS;
    localparam integer alarm_last = `RTCTK_ALARM_TICKS - 1;
    localparam [14:0] uip_at = `RTCTK_PRESCALE_MAX - uip_lead[14:0];

    ////////////////////////////////////////////////////////////////////////////
    // Format helper functions

    // Stored byte to plain binary
    function [7:0] f_to_bin;
        input [7:0] v;
        input bin_mode;
        begin
            f_to_bin = bin_mode ? v : ({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
        end
    endfunction

    // Plain binary to stored byte
    function [7:0] f_from_bin;
        input [7:0] b;
        input bin_mode;
        reg [7:0] tens;
        reg [7:0] ones;
        begin
            tens = b / 8'h0a;
            ones = b % 8'h0a;
            f_from_bin = bin_mode ? b : {tens[3:0], ones[3:0]};
        end
    endfunction

    // Days in a month, leap year when year divisible by four
    function [7:0] f_month_days;
        input [7:0] month_b;
        input [7:0] yr_b;
        begin
            case (month_b)
                8'h02: f_month_days = (yr_b[1:0] == 2'h0) ? 8'h1d : 8'h1c;
                8'h04, 8'h06, 8'h09, 8'h0b: f_month_days = 8'h1e;
                default: f_month_days = 8'h1f;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock source selection

    rtctk_clock_select u_clock_select (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .xtal_clock_in(xtal_clock_in),
        .backup_clock_in(backup_clock_in),
        .slow_clock(slow_clock),
        .slow_tick(slow_tick),
        .rc_selected(rc_selected)
    );

    assign set_mode = control[`RTCTK_CTL_SET_MODE];
    assign binary_mode = control[`RTCTK_CTL_DATA_MODE];
    assign hour_24 = control[`RTCTK_CTL_HOUR_24];

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and update sequencing

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prescale <= {`RTCTK_PRESCALE_BITS{1'b0}};
        end else if (slow_tick) begin
            prescale <= prescale + 15'h0001;
        end
    end

    assign second_tick = slow_tick && (prescale == `RTCTK_PRESCALE_MAX);
    assign uip_start = slow_tick && !set_mode && (prescale == uip_at);
    assign do_update = second_tick && !set_mode && update_pending_flag;
    assign do_compare = compare_pending && slow_tick && (compare_count == alarm_last[3:0]);

    // Update-pending flag and compare delay
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            update_pending_flag <= 1'b0;
            compare_pending <= 1'b0;
            compare_count <= 4'h0;
        end else begin
            if (uip_start) begin
                update_pending_flag <= 1'b1;
            end else if (do_compare || (set_mode && !compare_pending)) begin
                update_pending_flag <= 1'b0;
            end
            if (do_update) begin
                compare_pending <= 1'b1;
                compare_count <= 4'h0;
            end else if (do_compare) begin
                compare_pending <= 1'b0;
            end else if (compare_pending && slow_tick) begin
                compare_count <= compare_count + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next calendar values

    always @* begin
        for (k = 0; k < `RTCTK_DATA_BYTES; k = k + 1) begin
            next_byte[k] = data_byte[k];
        end
        sec_b = f_to_bin(data_byte[`RTCTK_IDX_SEC], binary_mode);
        min_b = f_to_bin(data_byte[`RTCTK_IDX_MIN], binary_mode);
        wday_b = data_byte[`RTCTK_IDX_WDAY];
        mday_b = f_to_bin(data_byte[`RTCTK_IDX_MDAY], binary_mode);
        mon_b = f_to_bin(data_byte[`RTCTK_IDX_MONTH], binary_mode);
        year_b = f_to_bin(data_byte[`RTCTK_IDX_YEAR], binary_mode);
        hr12_b = f_to_bin({1'b0, data_byte[`RTCTK_IDX_HOUR][6:0]}, binary_mode);
        if (hour_24) begin
            hr24_b = f_to_bin(data_byte[`RTCTK_IDX_HOUR], binary_mode);
        end else begin
            hr24_b = ((hr12_b == 8'h0c) ? 8'h00 : hr12_b) +
                (data_byte[`RTCTK_IDX_HOUR][`RTCTK_PM_BIT] ? 8'h0c : 8'h00);
        end
        carry_min = (sec_b >= 8'h3b);
        sec_b = carry_min ? 8'h00 : sec_b + 8'h01;
        carry_hr = carry_min && (min_b >= 8'h3b);
        min_b = carry_min ? (carry_hr ? 8'h00 : min_b + 8'h01) : min_b;
        carry_day = carry_hr && (hr24_b >= 8'h17);
        hr24_b = carry_hr ? (carry_day ? 8'h00 : hr24_b + 8'h01) : hr24_b;
        wday_b = carry_day ? ((wday_b >= 8'h07) ? 8'h01 : wday_b + 8'h01) : wday_b;
        carry_mon = carry_day && (mday_b >= f_month_days(mon_b, year_b));
        mday_b = carry_day ? (carry_mon ? 8'h01 : mday_b + 8'h01) : mday_b;
        carry_year = carry_mon && (mon_b >= 8'h0c);
        mon_b = carry_mon ? (carry_year ? 8'h01 : mon_b + 8'h01) : mon_b;
        year_b = carry_year ? ((year_b >= 8'h63) ? 8'h00 : year_b + 8'h01) : year_b;
        next_byte[`RTCTK_IDX_SEC] = f_from_bin(sec_b, binary_mode);
        next_byte[`RTCTK_IDX_MIN] = f_from_bin(min_b, binary_mode);
        if (hour_24) begin
            next_byte[`RTCTK_IDX_HOUR] = f_from_bin(hr24_b, binary_mode);
        end else begin
            hr12_b = hr24_b % 8'h0c;
            hr12_b = (hr12_b == 8'h00) ? 8'h0c : hr12_b;
            next_byte[`RTCTK_IDX_HOUR] = f_from_bin(hr12_b, binary_mode) |
                ((hr24_b >= 8'h0c) ? 8'h80 : 8'h00);
        end
        next_byte[`RTCTK_IDX_WDAY] = wday_b;
        next_byte[`RTCTK_IDX_MDAY] = f_from_bin(mday_b, binary_mode);
        next_byte[`RTCTK_IDX_MONTH] = f_from_bin(mon_b, binary_mode);
        next_byte[`RTCTK_IDX_YEAR] = f_from_bin(year_b, binary_mode);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    assign access_ok = spi_powered_in;
    assign wr_hit = access_ok && reg_write_in &&
        (reg_addr_in >= `RTCTK_ADDR_TIME_SECONDS) &&
        (reg_addr_in <= `RTCTK_ADDR_CALENDAR_YEAR);
    assign wr_index = reg_addr_in[3:0];
    assign rd_flags = access_ok && reg_read_in && (reg_addr_in == `RTCTK_ADDR_FLAGS);

    generate
        for (gi = 0; gi < `RTCTK_DATA_BYTES; gi = gi + 1) begin : g_data
            always @(posedge clock_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    if (gi == `RTCTK_IDX_WDAY) begin
                        data_byte[gi] <= `RTCTK_RESET_WEEKDAY;
                    end else if (gi == `RTCTK_IDX_MDAY) begin
                        data_byte[gi] <= `RTCTK_RESET_MONTH_DAY;
                    end else if (gi == `RTCTK_IDX_MONTH) begin
                        data_byte[gi] <= `RTCTK_RESET_MONTH;
                    end else begin
                        data_byte[gi] <= `RTCTK_RESET_YEAR;
                    end
                end else if (wr_hit && (wr_index == gi)) begin
                    data_byte[gi] <= reg_wdata_in;
                end else if (do_update) begin
                    data_byte[gi] <= next_byte[gi];
                end
            end
        end
    endgenerate

    // Control and charger registers
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            control <= `RTCTK_CTL_RESET;
            charger <= `RTCTK_CHARGER_RESET;
        end else if (access_ok && reg_write_in) begin
            if (reg_addr_in == `RTCTK_ADDR_CONTROL) begin
                control <= reg_wdata_in & `RTCTK_CTL_MASK;
            end
            if (reg_addr_in == `RTCTK_ADDR_CHARGER) begin
                charger <= reg_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm and update-ended flags

    assign alarm_match =
        (data_byte[`RTCTK_IDX_SEC] == data_byte[`RTCTK_IDX_ASEC]) &&
        (data_byte[`RTCTK_IDX_MIN] == data_byte[`RTCTK_IDX_AMIN]) &&
        (data_byte[`RTCTK_IDX_HOUR] == data_byte[`RTCTK_IDX_AHOUR]);

    always @* begin
        next_alarm_flag = (alarm_match_flag && !rd_flags) || (do_compare && alarm_match);
        next_update_flag = (update_end_flag && !rd_flags) || do_compare;
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alarm_match_flag <= 1'b0;
            update_end_flag <= 1'b0;
        end else begin
            alarm_match_flag <= next_alarm_flag;
            update_end_flag <= next_update_flag;
        end
    end

    assign request_flag =
        (alarm_match_flag && control[`RTCTK_CTL_ALARM_IE]) ||
        (update_end_flag && control[`RTCTK_CTL_UPDATE_IE]);

    ////////////////////////////////////////////////////////////////////////////
    // Read data path

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= access_ok && reg_read_in;
            if (access_ok && reg_read_in) begin
                if ((reg_addr_in >= `RTCTK_ADDR_TIME_SECONDS) &&
                    (reg_addr_in <= `RTCTK_ADDR_CALENDAR_YEAR)) begin
                    reg_rdata_out <= data_byte[reg_addr_in[3:0]];
                end else if (reg_addr_in == `RTCTK_ADDR_CONTROL) begin
                    reg_rdata_out <= control;
                end else if (reg_addr_in == `RTCTK_ADDR_STATUS) begin
                    reg_rdata_out <= {update_pending_flag, 6'h00, rc_selected};
                end else if (reg_addr_in == `RTCTK_ADDR_FLAGS) begin
                    reg_rdata_out <= {request_flag, 1'b0, alarm_match_flag,
                        update_end_flag, 4'h0};
                end else if (reg_addr_in == `RTCTK_ADDR_CHARGER) begin
                    reg_rdata_out <= charger;
                end else begin
                    reg_rdata_out <= 8'h00;
                end
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock outputs and interrupt line

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            driver_enable <= 1'b0;
        end else begin
            driver_enable <= startup_done_in && !control[`RTCTK_CTL_CLKOUT_DIS];
        end
    end

    // Audio pin synchroniser
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            audio_meta <= 1'b0;
            audio_sync <= 1'b0;
        end else begin
            audio_meta <= audio_clock_in;
            audio_sync <= audio_meta;
        end
    end

    // Registered pin outputs
    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slow_clock_out <= 1'b0;
            audio_clock_out <= 1'b0;
            rtc_irq_out <= 1'b0;
        end else begin
            slow_clock_out <= driver_enable && slow_clock;
            audio_clock_out <= companion_rail_in && audio_sync;
            rtc_irq_out <= request_flag;
        end
    end

endmodule // rtctk_timekeeper

`default_nettype wire

// [tb/rtctk_timekeeper_properties.sv]
// Port checker of the real-time clock timekeeper
`default_nettype none
module rtctk_props (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic companion_rail_in,
    input wire logic startup_done_in,
    input wire logic spi_powered_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic slow_clock_out,
    input wire logic audio_clock_out,
    input wire logic rtc_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    property p_audio_gate; !companion_rail_in |=> !audio_clock_out; endproperty
    a_audio_gate: assert property (p_audio_gate) else $error("audio out without rail");
    property p_read_answer; reg_read_in && spi_powered_in |=> reg_rvalid_out; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_no_stray; reg_rvalid_out |-> $past(reg_read_in && spi_powered_in); endproperty
    a_no_stray: assert property (p_no_stray) else $error("answer without read");
    property p_rdata_idle; !reg_rvalid_out |-> reg_rdata_out == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_unmapped;
        reg_read_in && spi_powered_in && (reg_addr_in < 8'h10 || reg_addr_in > 8'h1d)
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_slow_gate; !startup_done_in [*6] |-> !slow_clock_out; endproperty
    a_slow_gate: assert property (p_slow_gate) else $error("slow out before startup");
    property p_irq_fall;
        $fell(rtc_irq_out) |-> $past(reg_read_in) || $past(reg_read_in, 2)
            || $past(reg_write_in) || $past(reg_write_in, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
    property p_coin_mute; reg_read_in && !spi_powered_in |=> !reg_rvalid_out; endproperty
    a_coin_mute: assert property (p_coin_mute) else $error("read in coin-cell mode");
    c_read: cover property (reg_rvalid_out);
    c_audio: cover property ($rose(audio_clock_out));
    c_slow: cover property ($rose(slow_clock_out));
endmodule // rtctk_props
`default_nettype wire

// [tb/test_rtc_timekeeper_clock_select.sv]
// Self-checking bench of the real-time clock timekeeper
`default_nettype none
module test_rtc_timekeeper_clock_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, xtal = 0, bkp = 0, aud = 0, rail = 0, start = 0, pwr = 1;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic wr = 0, rd = 0, rv, sco, aco, irq, xen = 0, fast = 0;
    logic [7:0] tv [0:9] = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h31, 8'h12,
        8'h99};
    int fail_count = 0, compares = 0, n = 0;
    logic [31:0] seed = 32'h70901624;
    rtctk_timekeeper i_dut (.clock_in(clk), .sys_rst_in(rst), .xtal_clock_in(xtal),
        .backup_clock_in(bkp), .audio_clock_in(aud), .companion_rail_in(rail),
        .startup_done_in(start), .spi_powered_in(pwr), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdat),
        .reg_rvalid_out(rv), .slow_clock_out(sco), .audio_clock_out(aco), .rtc_irq_out(irq));
    // System clock
    initial begin
        forever #5 clk = ~clk;
    end
    // Crystal, backup and audio sources; crystal stands low when off
    always @(posedge clk) begin
        n <= n + 1;
        aud <= ~aud;
        if (n % 4 == 0) xtal <= xen & ~xtal;
        if (fast || n % 5 == 0) bkp <= ~bkp;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        if (a == 8'h1a) return 8'h02;
        if (a == 8'h16 || a == 8'h17 || a == 8'h18 || a == 8'h1b) return 8'h01;
        return 8'h00;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read answer is registered on the same edge that takes the strobe
    task automatic rreg(input logic [7:0] a, output logic [7:0] q, output logic ok);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        ok = rv;
        q = rdat;
        @(posedge clk);
    endtask
    // Counts slow and audio output high cycles
    task automatic watch(output int s, output int c);
        s = 0;
        c = 0;
        repeat (80) begin
            @(posedge clk);
            s += sco;
            c += aco;
        end
    endtask
    // Main sequence
    initial begin
        logic [7:0] q, e, sv;
        logic ok;
        int k, s, c;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (k = 8'h0f; k <= 8'h1e; k++) begin
            rreg(k[7:0], q, ok);
            check("reset value", q, rst_val(k[7:0]));
        end
        $display("test reset done");
        wreg(8'h1a, 8'h80);
        for (k = 0; k < 11; k++) begin
            seed = lfsr(seed);
            e = (k == 10) ? 8'h1d : 8'h10 + k[7:0];
            if (k == 0) sv = seed[7:0];
            wreg(e, seed[7:0]);
            rreg(e, q, ok);
            check("readback", q, seed[7:0]);
        end
        wreg(8'h1c, 8'hff);
        rreg(8'h1c, q, ok);
        check("flags", q, 8'h00);
        $display("test set mode done");
        @(posedge clk);
        pwr <= 1'b0;
        wreg(8'h10, ~sv);
        rreg(8'h10, q, ok);
        check("coin rvalid", ok, 1'b0);
        @(posedge clk);
        pwr <= 1'b1;
        rreg(8'h10, q, ok);
        check("coin keep", q, sv);
        $display("test coin cell done");
        start <= 1'b1;
        wreg(8'h1a, 8'hff);
        rreg(8'h1a, q, ok);
        check("control", q, 8'hd7);
        watch(s, c);
        check("slow off", s > 0, 1'b0);
        wreg(8'h1a, 8'h82);
        watch(s, c);
        check("slow on", s > 0, 1'b1);
        @(posedge clk);
        xen <= 1'b1;
        watch(s, c);
        rreg(8'h1b, q, ok);
        check("source xtal", q[0], 1'b0);
        @(posedge clk);
        xen <= 1'b0;
        watch(s, c);
        rreg(8'h1b, q, ok);
        check("source rc", q[0], 1'b1);
        $display("test clocks done");
        @(posedge clk);
        rail <= 1'b1;
        watch(s, c);
        check("audio on", c > 0, 1'b1);
        @(posedge clk);
        rail <= 1'b0;
        watch(s, c);
        check("audio off", c > 0, 1'b0);
        $display("test audio done");
        wreg(8'h1a, 8'h80);
        wreg(8'h1a, 8'h82);
        for (k = 0; k < 10; k++) wreg(8'h10 + k[7:0], tv[k]);
        wreg(8'h1a, 8'h42);
        fast <= 1'b1;
        for (k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge clk);
        check("irq rise", irq, 1'b1);
        if (irq !== 1'b1) complete_run();
        for (k = 8'h10; k <= 8'h19; k++) begin
            rreg(k[7:0], q, ok);
            check("rollover", q, rst_val(k[7:0]));
        end
        rreg(8'h1c, q, ok);
        check("flags set", q, 8'hb0);
        rreg(8'h1c, q, ok);
        check("flags cleared", q, 8'h00);
        check("irq cleared", irq, 1'b0);
        $display("test rollover done");
        complete_run();
    end
endmodule // test_rtc_timekeeper_clock_select
bind rtctk_timekeeper rtctk_props i_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .companion_rail_in(companion_rail_in), .startup_done_in(startup_done_in),
    .spi_powered_in(spi_powered_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .slow_clock_out(slow_clock_out), .audio_clock_out(audio_clock_out),
    .rtc_irq_out(rtc_irq_out));
`default_nettype wire
